// file: rtl/sop_pkg.sv
package sop_pkg;
  // Byte addresses of the registers on the APB port.
  localparam logic [7:0] SOP_ADDR_OPTION = 8'h39;
  localparam logic [7:0] SOP_ADDR_PRIO = 8'h3c;
  localparam logic [7:0] SOP_ADDR_SERVICE = 8'h40;
  localparam logic [7:0] SOP_ADDR_IRQ_STATUS = 8'h44;
  localparam logic [7:0] SOP_ADDR_IRQ_MASK = 8'h48;
  localparam logic [7:0] SOP_ADDR_CTRL = 8'h4c;
  // Reset values.
  localparam logic [7:0] SOP_OPTION_RESET = 8'h10;
  localparam logic [4:0] SOP_PRIO_RESET = 5'h06;
  // Option field positions.
  localparam int SOP_BIT_IRQ_EDGE_SENSE = 5;
  localparam int SOP_BIT_DLY = 4;
  localparam int SOP_BIT_CME = 3;
  localparam int SOP_BIT_CLOCK_MONITOR_FORCE = 2;
  localparam logic [7:0] SOP_OPTION_PROTECT = 8'h37;
  // Watchdog service keys.
  localparam logic [7:0] SOP_KEY_ARM = 8'h55;
  localparam logic [7:0] SOP_KEY_CLEAR = 8'haa;
  // Timing, counter width and priority codes.
  localparam int SOP_PROTECT_CYCLES = 64;
  localparam int SOP_WDOG_EXP_BASE = 15;
  localparam int SOP_WDOG_EXP_STEP = 2;
  localparam int SOP_WDOG_CNT_W = 22;
  localparam logic [4:0] SOP_PRIO_IRQ = 5'h06;
  localparam logic [4:0] SOP_PRIO_MAX = 5'h14;
  // Interrupt status bits.
  localparam int SOP_EV_WDOG = 0;
  localparam int SOP_EV_CLKFAIL = 1;
  localparam int SOP_EV_IRQ = 2;
  localparam int SOP_EV_STOPEXIT = 3;
  localparam int SOP_EV_W = 4;
  // Stop exit state machine.
  typedef enum logic [1:0] {SOP_RUN = 2'b00, SOP_STOP = 2'b01, SOP_WAKE = 2'b11} sop_stop_e;
  // Mode bits held in the priority register.
  typedef struct packed {
    logic boot_rom_read;
    logic special_mode_select;
    logic mode_select_a;
  } sop_mode_s;
endpackage : sop_pkg

// file: rtl/sop_irq_sense.sv
`timescale 1ns/1ps
`default_nettype none
// Senses the external request as a level or a falling edge.
module sop_irq_sense
  import sop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_n,
  input wire logic edge_mode,
  input wire logic ack,
  output logic pending
);
  typedef struct packed {
    logic prev;
    logic latch;
  } sop_sense_s;
  sop_sense_s s_reg, s_next;

  // Latch a falling edge until acknowledged; a new edge wins over the acknowledge.
  always_comb
  begin
    s_next = s_reg;
    s_next.prev = irq_n;
    if (ack)
      s_next.latch = 1'b0;
    if (s_reg.prev && !irq_n)
      s_next.latch = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '{prev: 1'b1, latch: 1'b0};
    else
      s_reg <= s_next;
  end

  // Level while low, or the held edge.
  assign pending = edge_mode ? s_reg.latch : !irq_n;
endmodule : sop_irq_sense
`default_nettype wire

// file: rtl/sop_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
// Watchdog counter with the two-write service sequence.
module sop_watchdog
  import sop_pkg::*;
#(
  parameter int CNT_W = SOP_WDOG_CNT_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [1:0] rate,
  input wire logic svc_wr,
  input wire logic [7:0] svc_data,
  output logic timeout
);
  typedef struct packed {
    logic armed;
    logic [CNT_W-1:0] cnt;
    logic timeout;
  } sop_wd_s;
  sop_wd_s s_reg, s_next;

  // Terminal count for a rate code.
  function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] r);
    int e;
    e = SOP_WDOG_EXP_BASE + SOP_WDOG_EXP_STEP * int'(r);
    wd_limit = CNT_W'((64'd1 << e) - 64'd1);
  endfunction : wd_limit

  // Arm on 55, restart only on an armed AA, pulse on expiry.
  always_comb
  begin
    s_next = s_reg;
    s_next.timeout = 1'b0;
    if (enable)
      s_next.cnt = s_reg.cnt + 1'b1;
    if (enable && s_reg.cnt >= wd_limit(rate))
    begin
      s_next.timeout = 1'b1;
      s_next.cnt = '0;
    end
    if (svc_wr)
    begin
      if (svc_data == SOP_KEY_ARM)
        s_next.armed = 1'b1;
      else if (svc_data == SOP_KEY_CLEAR && s_reg.armed)
      begin
        s_next.cnt = '0;
        s_next.armed = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign timeout = s_reg.timeout;
endmodule : sop_watchdog
`default_nettype wire

// file: rtl/sop_system_option.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Option register, watchdog, clock monitor, stop exit and priority select.
module sop_system_option
  import sop_pkg::*;
#(
  parameter int STOP_DELAY_CYCLES = 4064,
  parameter int MONITOR_TIMEOUT = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] mode_strap,
  input wire logic cpu_irq_mask,
  input wire logic irq_n,
  input wire logic irq_ack,
  input wire logic watchdog_disable,
  input wire logic clk_tick,
  input wire logic stop_req,
  input wire logic wake_req,
  output logic irq_pending,
  output logic [4:0] promoted_source,
  output logic resume,
  output logic watchdog_reset,
  output logic clock_fail_reset,
  output logic converter_power_on,
  output logic converter_clock_choice,
  output logic [2:0] mode_bits,
  output logic interrupt
);
  localparam int SOP_OPTION_W = 1;
  typedef struct packed {
    logic [7:0] option;
    logic [SOP_OPTION_W-1:0] written;
    logic [6:0] protect_cnt;
    logic strap_taken;
    sop_mode_s mode;
    logic [4:0] prio;
    logic [4:0] promoted;
    sop_stop_e stop_st;
    logic [12:0] stop_cnt;
    logic [4:0] mon_cnt;
    logic clock_fail;
    logic resume;
    logic irq_pending;
    logic [SOP_EV_W-1:0] status;
    logic [SOP_EV_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic interrupt;
  } sop_state_s;
  sop_state_s s_reg, s_next;

  logic irq_seen;
  logic wd_timeout;
  logic svc_wr;
  logic wr_acc;
  logic monitor_on;

  // Maps a priority code to the promoted source.
  function automatic logic [4:0] prio_map(input logic [4:0] c);
    if (c < SOP_PRIO_IRQ || c > SOP_PRIO_MAX)
      prio_map = SOP_PRIO_IRQ;
    else
      prio_map = c;
  endfunction : prio_map

  assign wr_acc = psel && penable && pwrite && !s_reg.pready;
  assign svc_wr = wr_acc && paddr == SOP_ADDR_SERVICE;
  assign monitor_on = s_reg.option[SOP_BIT_CME] || s_reg.option[SOP_BIT_CLOCK_MONITOR_FORCE];

  sop_irq_sense u_sense (
    .pclk(pclk),
    .presetn(presetn),
    .irq_n(irq_n),
    .edge_mode(s_reg.option[SOP_BIT_IRQ_EDGE_SENSE]),
    .ack(irq_ack),
    .pending(irq_seen)
  );

  sop_watchdog u_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .enable(!watchdog_disable),
    .rate(s_reg.option[1:0]),
    .svc_wr(svc_wr),
    .svc_data(pwdata[7:0]),
    .timeout(wd_timeout)
  );

  // All register, monitor, stop and interrupt behaviour.
  always_comb
  begin
    logic [SOP_EV_W-1:0] ev;
    logic special;
    ev = '0;
    s_next = s_reg;
    special = s_reg.mode.special_mode_select;
    // Strap capture once after reset release.
    if (!s_reg.strap_taken)
    begin
      s_next.strap_taken = 1'b1;
      s_next.mode = sop_mode_s'(mode_strap);
    end
    if (s_reg.protect_cnt != 7'(SOP_PROTECT_CYCLES))
      s_next.protect_cnt = s_reg.protect_cnt + 7'h01;
    // APB slave: one wait cycle, answer in the second access cycle.
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = 1'b0;
    if (psel && penable && !s_reg.pready)
    begin
      s_next.prdata = 32'h0;
      case (paddr)
        SOP_ADDR_OPTION:
        begin
          s_next.prdata = {24'h0, s_reg.option};
          if (pwrite)
          begin
            s_next.option[7:6] = pwdata[7:6];
            s_next.option[SOP_BIT_CME] = pwdata[SOP_BIT_CME];
            if (special || (s_reg.written == 1'b0 && s_reg.protect_cnt < 7'(SOP_PROTECT_CYCLES)))
            begin
              s_next.option = (s_next.option & ~SOP_OPTION_PROTECT) | (pwdata[7:0] & SOP_OPTION_PROTECT);
              s_next.written = 1'b1;
            end
            // Force stays set until reset.
            if (s_reg.option[SOP_BIT_CLOCK_MONITOR_FORCE])
              s_next.option[SOP_BIT_CLOCK_MONITOR_FORCE] = 1'b1;
          end
        end
        SOP_ADDR_PRIO:
        begin
          s_next.prdata = {24'h0, s_reg.mode, s_reg.prio};
          if (pwrite && cpu_irq_mask)
            s_next.prio = pwdata[4:0];
          if (pwrite && special)
            s_next.mode = sop_mode_s'(pwdata[7:5]);
        end
        SOP_ADDR_SERVICE: s_next.prdata = 32'h0;
        SOP_ADDR_IRQ_STATUS:
        begin
          s_next.prdata = {28'h0, s_reg.status};
          if (pwrite)
            s_next.status = s_reg.status & ~pwdata[SOP_EV_W-1:0];
        end
        SOP_ADDR_IRQ_MASK:
        begin
          s_next.prdata = {28'h0, s_reg.mask};
          if (pwrite)
            s_next.mask = pwdata[SOP_EV_W-1:0];
        end
        SOP_ADDR_CTRL: s_next.prdata = {27'h0, s_reg.promoted};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    s_next.promoted = prio_map(s_reg.prio);
    // Clock monitor: missing ticks for too long trip a reset.
    s_next.clock_fail = 1'b0;
    if (!monitor_on || clk_tick)
      s_next.mon_cnt = '0;
    else if (s_reg.mon_cnt == 5'(MONITOR_TIMEOUT))
    begin
      s_next.clock_fail = 1'b1;
      s_next.mon_cnt = '0;
    end
    else
      s_next.mon_cnt = s_reg.mon_cnt + 5'h01;
    // Stop mode exit with optional stabilization delay.
    s_next.resume = 1'b0;
    case (s_reg.stop_st)
      SOP_RUN:
        if (stop_req)
          s_next.stop_st = SOP_STOP;
      SOP_STOP:
        if (wake_req)
        begin
          if (s_reg.option[SOP_BIT_DLY])
          begin
            s_next.stop_st = SOP_WAKE;
            s_next.stop_cnt = '0;
          end
          else
          begin
            s_next.stop_st = SOP_RUN;
            s_next.resume = 1'b1;
          end
        end
      SOP_WAKE:
        if (s_reg.stop_cnt == 13'(STOP_DELAY_CYCLES - 1))
        begin
          s_next.stop_st = SOP_RUN;
          s_next.resume = 1'b1;
        end
        else
          s_next.stop_cnt = s_reg.stop_cnt + 13'h0001;
      default: s_next.stop_st = SOP_RUN;
    endcase
    s_next.irq_pending = irq_seen;
    // Sticky events; a set in the clearing cycle wins.
    ev[SOP_EV_WDOG] = wd_timeout;
    ev[SOP_EV_CLKFAIL] = s_reg.clock_fail;
    ev[SOP_EV_IRQ] = irq_seen && !s_reg.irq_pending;
    ev[SOP_EV_STOPEXIT] = s_reg.resume;
    s_next.status = s_next.status | ev;
    s_next.interrupt = |(s_next.status & s_next.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '{option: SOP_OPTION_RESET, prio: SOP_PRIO_RESET, promoted: SOP_PRIO_RESET,
                 stop_st: SOP_RUN, default: '0};
    else
      s_reg <= s_next;
  end

  // Outputs straight from flip-flops.
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq_pending = s_reg.irq_pending;
  assign promoted_source = s_reg.promoted;
  assign resume = s_reg.resume;
  assign watchdog_reset = wd_timeout;
  assign clock_fail_reset = s_reg.clock_fail;
  assign converter_power_on = s_reg.option[7];
  assign converter_clock_choice = s_reg.option[6];
  assign mode_bits = s_reg.mode;
  assign interrupt = s_reg.interrupt;
endmodule : sop_system_option
`default_nettype wire

// file: dv/sop_system_option_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the bus timing and the pulse outputs of the option block.
module sop_system_option_asserts
  import sop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic watchdog_disable,
  input wire logic clk_tick,
  input wire logic resume,
  input wire logic watchdog_reset,
  input wire logic clock_fail_reset,
  input wire logic [4:0] promoted_source
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The two phases of a bus transfer.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_prio_range: assert property (promoted_source >= SOP_PRIO_IRQ && promoted_source <= SOP_PRIO_MAX)
    else $error("promoted source out of range");
  a_resume_pulse: assert property (resume |=> !resume)
    else $error("resume longer than one cycle");
  a_monitor_fed: assert property (clk_tick [*3] |-> !clock_fail_reset)
    else $error("clock fail while ticks arrive");
  a_wdog_off: assert property (watchdog_disable [*3] |-> !watchdog_reset)
    else $error("watchdog fired while disabled");
  a_fail_pulse: assert property (clock_fail_reset |=> !clock_fail_reset)
    else $error("clock fail longer than one cycle");
endmodule : sop_system_option_asserts
bind sop_system_option sop_system_option_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .watchdog_disable(watchdog_disable), .clk_tick(clk_tick), .resume(resume),
  .watchdog_reset(watchdog_reset), .clock_fail_reset(clock_fail_reset), .promoted_source(promoted_source));
`default_nettype wire

// file: dv/sop_system_option_test.sv
`timescale 1ns/1ps
`default_nettype none
module sop_system_option_test
  import sop_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_irq_mask, irq_n, irq_ack;
  logic wd_off, clk_tick, stop_req, wake_req, irq_pending, resume, watchdog_reset, clock_fail_reset;
  logic interrupt, er;
  logic [7:0] paddr, rv;
  logic [31:0] pwdata, prdata;
  logic [4:0] promoted_source;
  logic [2:0] mode_bits, strap;
  int failures, n_tests, wd_cnt, cf_cnt;
  sop_system_option #(.STOP_DELAY_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_strap(strap), .cpu_irq_mask(cpu_irq_mask), .irq_n(irq_n), .irq_ack(irq_ack),
    .watchdog_disable(wd_off), .clk_tick(clk_tick), .stop_req(stop_req), .wake_req(wake_req),
    .irq_pending(irq_pending), .promoted_source(promoted_source), .resume(resume),
    .watchdog_reset(watchdog_reset), .clock_fail_reset(clock_fail_reset), .converter_power_on(),
    .converter_clock_choice(), .mode_bits(mode_bits), .interrupt(interrupt));
  // Clock of 20 ns.
  initial
  begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  // Counts the reset pulses.
  always @(posedge pclk)
  begin
    wd_cnt <= wd_cnt + (watchdog_reset === 1'b1);
    cf_cnt <= cf_cnt + (clock_fail_reset === 1'b1);
  end
  task chk(input string s, input logic [31:0] v, input logic [31:0] e);
    n_tests++;
    if (v !== e)
    begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", s, e, v);
    end
  endtask : chk
  task results;
    $display("failures %0d tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // One APB transfer; waits for pready under a bound.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // A transfer that never completes counts as a mismatch.
    if (pready !== 1'b1)
      failures++;
    rv = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task t_reset;
    apb(0, SOP_ADDR_OPTION, 0);
    chk("option reset", rv, 8'h10);
    apb(0, SOP_ADDR_PRIO, 0);
    chk("prio reset", rv, 8'ha6);
    irq_n <= 0;
    cyc(2);
    chk("level low", irq_pending, 1);
    irq_n <= 1;
    cyc(2);
    chk("level high", irq_pending, 0);
    irq_ack <= 1;
    cyc(1);
    irq_ack <= 0;
  endtask : t_reset
  task t_stop(input bit dly);
    int n;
    stop_req <= 1;
    cyc(1);
    stop_req <= 0;
    cyc(2);
    wake_req <= 1;
    cyc(1);
    wake_req <= 0;
    n = 0;
    while (resume !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk("stop exit", dly ? (n > 5 && n < 20) : (n < 4), 1);
  endtask : t_stop
  task t_option;
    apb(1, SOP_ADDR_OPTION, 8'h20);
    apb(0, SOP_ADDR_OPTION, 0);
    chk("first write", rv, 8'h20);
    apb(1, SOP_ADDR_OPTION, 8'h33);
    apb(0, SOP_ADDR_OPTION, 0);
    chk("second write", rv, 8'h20);
    apb(1, 8'h50, 8'h01);
    chk("unmapped", er, 1);
  endtask : t_option
  task t_irq;
    irq_n <= 0;
    cyc(3);
    chk("edge seen", irq_pending, 1);
    irq_ack <= 1;
    cyc(1);
    irq_ack <= 0;
    cyc(3);
    chk("edge held low", irq_pending, 0);
    apb(0, SOP_ADDR_IRQ_STATUS, 0);
    chk("status", rv[2], 1);
    chk("masked", interrupt, 0);
    apb(1, SOP_ADDR_IRQ_MASK, 8'h04);
    cyc(1);
    chk("unmasked", interrupt, 1);
    apb(1, SOP_ADDR_IRQ_STATUS, 8'hff);
    cyc(1);
    chk("cleared", interrupt, 0);
    irq_n <= 1;
  endtask : t_irq
  task t_prio;
    cpu_irq_mask <= 0;
    apb(1, SOP_ADDR_PRIO, 8'h07);
    cyc(1);
    chk("mask clear", promoted_source, 6);
    cpu_irq_mask <= 1;
    for (int c = 0; c < 32; c++)
    begin
      apb(1, SOP_ADDR_PRIO, c[7:0]);
      cyc(1);
      chk("promoted", promoted_source, (c >= 6 && c <= 20) ? c : 6);
    end
    chk("mode bits", mode_bits, 3'b101);
  endtask : t_prio
  task t_mon(input logic [7:0] opt, input bit trip);
    int n;
    apb(1, SOP_ADDR_OPTION, opt);
    n = cf_cnt;
    clk_tick <= 0;
    cyc(25);
    clk_tick <= 1;
    cyc(2);
    chk("monitor", cf_cnt > n, trip);
  endtask : t_mon
  task t_wdog;
    int n;
    n = wd_cnt;
    wd_off <= 0;
    cyc(20000);
    apb(1, SOP_ADDR_SERVICE, SOP_KEY_ARM);
    apb(1, SOP_ADDR_SERVICE, SOP_KEY_CLEAR);
    cyc(20000);
    chk("restarted", wd_cnt, n);
    apb(1, SOP_ADDR_SERVICE, SOP_KEY_CLEAR);
    cyc(14000);
    chk("unarmed", wd_cnt > n, 1);
  endtask : t_wdog
  // Mid-run reset into a special mode: mode bits and protected option bits stay writable.
  task t_special;
    wd_off <= 1;
    strap <= 3'b010;
    presetn <= 0;
    cyc(2);
    presetn <= 1;
    cyc(2);
    chk("special strap", mode_bits, 3'b010);
    apb(1, SOP_ADDR_PRIO, 8'h47);
    cyc(1);
    chk("special mode write", mode_bits, 3'b010);
    chk("special prio", promoted_source, 7);
    apb(1, SOP_ADDR_PRIO, 8'he6);
    cyc(1);
    chk("mode bits written", mode_bits, 3'b111);
    apb(1, SOP_ADDR_OPTION, 8'h20);
    apb(1, SOP_ADDR_OPTION, 8'h31);
    apb(0, SOP_ADDR_OPTION, 0);
    chk("special rewrite", rv, 8'h31);
  endtask : t_special
  // Hang guard.
  initial
  begin
    cyc(100000);
    failures++;
    results();
  end
  // Main sequence.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, irq_ack, stop_req, wake_req} = 0;
    {presetn, cpu_irq_mask} = 0;
    {irq_n, wd_off, clk_tick} = 3'b111;
    strap = 3'b101;
    cyc(2);
    presetn <= 1;
    t_reset();
    t_stop(1);
    t_option();
    t_stop(0);
    t_irq();
    t_prio();
    t_mon(8'h28, 1);
    t_mon(8'h20, 0);
    t_wdog();
    t_special();
    results();
  end
endmodule : sop_system_option_test
`default_nettype wire
